// File: verilog/stc_pkg.sv
package stc_pkg;

   // Register byte addresses on the Avalon-MM slave.
   localparam logic [5:0] OFF_DATA     = 6'h00;
   localparam logic [5:0] OFF_STATUS   = 6'h04;
   localparam logic [5:0] OFF_FLAG_CLR = 6'h08;
   localparam logic [5:0] OFF_STOP_TRG = 6'h0C;
   localparam logic [5:0] OFF_STRT_TRG = 6'h10;
   localparam logic [5:0] OFF_ENABLE   = 6'h14;
   localparam logic [5:0] OFF_CTRL     = 6'h18;
   localparam logic [5:0] OFF_IRQ_STAT = 6'h1C;
   localparam logic [5:0] OFF_IRQ_MASK = 6'h20;

   // Field positions in the channel status register.
   localparam int ST_OVERRUN = 0;
   localparam int ST_ACK_ERR = 1;
   localparam int ST_BUF_FUL = 5;
   localparam int ST_BUSY    = 6;

   // Field positions in the control register.
   localparam int CT_RX_MODE = 0;
   localparam int CT_ACK_EN  = 1;
   localparam int CT_GEN_STA = 2;
   localparam int CT_GEN_STP = 3;

   // Field positions in the interrupt status and mask registers.
   localparam int IR_DONE = 0;
   localparam int IR_ERR  = 1;

   // Divider field position in the data register and its reset value.
   localparam int         DIV_LSB   = 9;
   localparam logic [6:0] DIV_RESET = 7'h01;

   // Bits shifted per byte, including the acknowledge slot.
   localparam logic [3:0] BITS_PER_BYTE = 4'h9;

   // Engine states.
   typedef enum logic [3:0] {
      STC_IDLE, STC_STA0, STC_STA1, STC_STA2, STC_SP0, STC_SP1, STC_SP2, STC_BLO, STC_BHI
   } stc_state_t;

endpackage

// File: verilog/stc_pin_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for the two bus wires, with a rising-edge pulse on the clock wire.
module stc_pin_sync (
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic srst,
   // Raw wire levels.
   input  wire logic scl_i,
   input  wire logic sda_i,
   // Synchronised levels and clock rise.
   output logic      scl_s,
   output logic      sda_s,
   output logic      scl_rise
);

   logic [1:0] scl_ff_q;   // First stage feeds only the second.
   logic [1:0] sda_ff_q;   // Same structure for the data wire.
   logic       scl_old_q;  // Previous synchronised clock level.

   // Idle wires are high, so reset to high to avoid a false edge.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         scl_ff_q  <= 2'h3;
         sda_ff_q  <= 2'h3;
         scl_old_q <= 1'b1;
      end else begin
         scl_ff_q  <= {scl_ff_q[0], scl_i};
         sda_ff_q  <= {sda_ff_q[0], sda_i};
         scl_old_q <= scl_ff_q[1];
      end
   end

   assign scl_s    = scl_ff_q[1];
   assign sda_s    = sda_ff_q[1];
   assign scl_rise = scl_ff_q[1] & ~scl_old_q;

endmodule

// File: verilog/stc_channel.sv
`timescale 1ns/1ps

// Behaviour
// [R1] Data read clears buffer-full, accepts next byte.
// [R2] Software reads data first during overrun recovery.
// [R3] Status register reports which error occurred.
// [R4] Writing one to flag-clear clears that flag.
// [R5] Writing back status clears only flags read.
// [R6] Stop trigger clears enable status, halts channel.
// [R7] Start trigger sets enable status, resumes channel.
// [R8] Ack error recovery: clear, stop, conditions, restart.
// [R9] Alternatively repeated start, redo from address.
// [R10] Divider field nonzero; rate clock/(div+1)/2.
// [R11] Error flags hold until cleared or reset.
module stc_channel (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Avalon-MM slave.
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Interrupt.
   output logic             irq,
   // Open-drain clock wire.
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   // Open-drain data wire.
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);

   stc_pkg::stc_state_t state_q, state_d;   // Engine state.
   logic [6:0]  div_q;       // Half-period divider.
   logic [6:0]  cnt_q;       // Half-period counter.
   logic [7:0]  shift_q;     // Byte being shifted.
   logic [7:0]  rx_q;        // Received byte.
   logic [3:0]  bit_q;       // Bits left in the byte.
   logic        ovr_q;       // Overrun error flag.
   logic        ack_err_q;   // Missing acknowledge flag.
   logic        bff_q;       // Receive buffer full.
   logic        en_q;        // Channel enable status.
   logic [3:0]  ctrl_q;      // Mode bits; command bits read back as zero.
   logic [1:0]  irq_st_q;    // Sticky interrupt causes.
   logic [1:0]  irq_mk_q;    // Interrupt mask.
   logic        wait_q;      // Registered waitrequest.
   logic [31:0] rdata_q;     // Registered read data.
   logic        irq_q;       // Registered interrupt.
   logic        scl_oe_q;    // Clock wire pulled low.
   logic        sda_oe_q;    // Data wire pulled low.
   logic        low_q;       // Level driven when enabled.
   logic        scl_s, sda_s, scl_rise;

   // Wire synchroniser; nothing reads the raw pins.
   stc_pin_sync u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .scl_i    (scl_i),
      .sda_i    (sda_i),
      .scl_s    (scl_s),
      .sda_s    (sda_s),
      .scl_rise (scl_rise)
   );

   // True when a register access at this address completes at this edge.
   function automatic logic hit(input logic [5:0] a, input logic [5:0] off, input logic go);
      hit = go & (a == off);
   endfunction

   // Bus strobes fire on the edge at which waitrequest is seen low.
   wire       wr_go   = write & ~wait_q;
   wire       rd_go   = read & ~wait_q;
   wire       wr_data = hit(address, stc_pkg::OFF_DATA, wr_go);
   wire       wr_fclr = hit(address, stc_pkg::OFF_FLAG_CLR, wr_go) & byteenable[0];
   wire       wr_stop = hit(address, stc_pkg::OFF_STOP_TRG, wr_go) & byteenable[0];
   wire       wr_strt = hit(address, stc_pkg::OFF_STRT_TRG, wr_go) & byteenable[0];
   wire       wr_ctrl = hit(address, stc_pkg::OFF_CTRL, wr_go) & byteenable[0];
   wire       wr_ist  = hit(address, stc_pkg::OFF_IRQ_STAT, wr_go) & byteenable[0];
   wire       wr_imk  = hit(address, stc_pkg::OFF_IRQ_MASK, wr_go) & byteenable[0];
   wire       rd_data = hit(address, stc_pkg::OFF_DATA, rd_go);
   wire       busy    = (state_q != stc_pkg::STC_IDLE);

   // Half period elapsed: div+1 cycles per half gives clock/(div+1)/2.
   wire       half    = (cnt_q == div_q); // [R10]
   // High phases count only once the wire is really high, so a stretched clock waits.
   wire       hi_ok   = half & scl_s;
   wire       xfer    = (state_q == stc_pkg::STC_BLO) | (state_q == stc_pkg::STC_BHI);
   // A halted channel abandons a byte at once.
   wire       halt    = xfer & ~en_q; // [R6]
   wire       last    = (state_q == stc_pkg::STC_BHI) & hi_ok & (bit_q == 4'h1);
   wire       rx_mode = ctrl_q[stc_pkg::CT_RX_MODE];
   wire       rx_end  = last & rx_mode;
   wire       nack    = last & ~rx_mode & sda_s;
   // Reception into a still-full buffer is an overrun; reading data first avoids it.
   wire       ovr_set = rx_end & bff_q; // [R2]
   wire       err_set = ovr_set | nack;
   wire [1:0] ist_set = {err_set, last};

   // Status word: error flags are exactly the bits a flag-clear write addresses.
   wire [31:0] status_w = {25'h0, busy, bff_q, 3'h0, ack_err_q, ovr_q}; // [R3]

   // Read multiplexer; unmapped addresses read zero.
   wire [31:0] rd_mux =
      (address == stc_pkg::OFF_DATA)     ? {16'h0, div_q, 1'b0, rx_q} :
      (address == stc_pkg::OFF_STATUS)   ? status_w :
      (address == stc_pkg::OFF_ENABLE)   ? {31'h0, en_q} :
      (address == stc_pkg::OFF_CTRL)     ? {30'h0, ctrl_q[1:0]} :
      (address == stc_pkg::OFF_IRQ_STAT) ? {30'h0, irq_st_q} :
      (address == stc_pkg::OFF_IRQ_MASK) ? {30'h0, irq_mk_q} : 32'h0;

   // Next state of the wire engine.
   // Conditions run even while the channel is halted so software can free the bus.
   always_comb begin
      state_d = state_q;
      case (state_q)
         stc_pkg::STC_IDLE: begin
            if (wr_ctrl & writedata[stc_pkg::CT_GEN_STA]) begin
               state_d = stc_pkg::STC_STA0; // [R8]
            end else if (wr_ctrl & writedata[stc_pkg::CT_GEN_STP]) begin
               state_d = stc_pkg::STC_SP0; // [R8]
            end else if (wr_data & byteenable[0] & en_q) begin
               state_d = stc_pkg::STC_BLO;
            end
         end
         // Release data first so a repeated start works from a low clock.
         stc_pkg::STC_STA0: if (half) state_d = stc_pkg::STC_STA1; // [R9]
         stc_pkg::STC_STA1: if (hi_ok) state_d = stc_pkg::STC_STA2;
         stc_pkg::STC_STA2: if (half) state_d = stc_pkg::STC_IDLE;
         stc_pkg::STC_SP0:  if (half) state_d = stc_pkg::STC_SP1;
         stc_pkg::STC_SP1:  if (hi_ok) state_d = stc_pkg::STC_SP2;
         stc_pkg::STC_SP2:  if (half) state_d = stc_pkg::STC_IDLE;
         stc_pkg::STC_BLO:  if (half) state_d = stc_pkg::STC_BHI;
         stc_pkg::STC_BHI: begin
            if (hi_ok) begin
               state_d = last ? stc_pkg::STC_IDLE : stc_pkg::STC_BLO;
            end
         end
         default: state_d = stc_pkg::STC_IDLE;
      endcase
      if (halt) begin
         state_d = stc_pkg::STC_IDLE; // [R6]
      end
   end

   // Engine registers and wire drives.
   // The clock is released after each byte; the next byte or a stop pulls it low again.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q  <= stc_pkg::STC_IDLE;
         cnt_q    <= 7'h00;
         bit_q    <= 4'h0;
         shift_q  <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= (state_d != state_q || half) ? 7'h00 : 7'(cnt_q + 7'h01);
         case (state_q)
            stc_pkg::STC_IDLE: begin
               if (state_d == stc_pkg::STC_BLO) begin
                  shift_q <= rx_mode ? 8'hFF : writedata[7:0];
                  bit_q   <= stc_pkg::BITS_PER_BYTE;
               end
               if (state_d == stc_pkg::STC_SP0) begin
                  scl_oe_q <= 1'b1;
               end
            end
            stc_pkg::STC_STA0: sda_oe_q <= 1'b0;
            stc_pkg::STC_STA1: scl_oe_q <= 1'b0;
            stc_pkg::STC_STA2: begin
               sda_oe_q <= 1'b1;
               if (half) scl_oe_q <= 1'b1;
            end
            stc_pkg::STC_SP0: sda_oe_q <= 1'b1;
            stc_pkg::STC_SP1: scl_oe_q <= 1'b0;
            stc_pkg::STC_SP2: if (half) sda_oe_q <= 1'b0;
            stc_pkg::STC_BLO: begin
               scl_oe_q <= 1'b1;
               // Data moves only once the clock is already low, so a data edge never
               // meets a falling clock and looks like a start or stop to the target.
               // Ninth slot: receiver drives acknowledge, transmitter releases.
               if (scl_oe_q && bit_q == 4'h1) begin
                  sda_oe_q <= rx_mode & ctrl_q[stc_pkg::CT_ACK_EN];
               end else if (scl_oe_q) begin
                  sda_oe_q <= ~shift_q[7];
               end
            end
            stc_pkg::STC_BHI: begin
               scl_oe_q <= 1'b0;
               if (scl_rise && bit_q != 4'h1) begin
                  shift_q <= {shift_q[6:0], sda_s};
               end
               if (hi_ok) bit_q <= 4'(bit_q - 4'h1);
            end
            default: scl_oe_q <= scl_oe_q;
         endcase
      end
   end

   // Flags, enable and receive buffer; a hardware set beats a same-cycle clear.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ovr_q     <= 1'b0;
         ack_err_q <= 1'b0;
         bff_q     <= 1'b0;
         rx_q      <= 8'h00;
         en_q      <= 1'b0;
      end else begin
         ovr_q     <= ovr_set | (ovr_q & ~(wr_fclr & writedata[stc_pkg::ST_OVERRUN])); // [R4] [R5] [R11]
         ack_err_q <= nack | (ack_err_q & ~(wr_fclr & writedata[stc_pkg::ST_ACK_ERR])); // [R4] [R5] [R11]
         bff_q     <= rx_end | (bff_q & ~rd_data); // [R1]
         if (rx_end & ~bff_q) rx_q <= shift_q; // [R1]
         if (wr_stop & writedata[0]) begin
            en_q <= 1'b0; // [R6]
         end else if (wr_strt & writedata[0]) begin
            en_q <= 1'b1; // [R7]
         end
      end
   end

   // Software-written configuration.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         div_q    <= stc_pkg::DIV_RESET;
         ctrl_q   <= 4'h0;
         irq_mk_q <= 2'h0;
      end else begin
         if (wr_data & byteenable[1] & ~busy) div_q <= writedata[15:stc_pkg::DIV_LSB];
         if (wr_ctrl) ctrl_q <= {2'h0, writedata[1:0]};
         if (wr_imk) irq_mk_q <= writedata[1:0];
      end
   end

   // Bus answer, interrupt causes and line outputs, all registered.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wait_q   <= 1'b1;
         rdata_q  <= 32'h0;
         irq_st_q <= 2'h0;
         irq_q    <= 1'b0;
         low_q    <= 1'b0;
      end else begin
         wait_q   <= ~((read | write) & wait_q);
         rdata_q  <= rd_mux;
         irq_st_q <= ist_set | (irq_st_q & ~({2{wr_ist}} & writedata[1:0]));
         irq_q    <= |(irq_st_q & irq_mk_q);
         low_q    <= 1'b0;
      end
   end

   assign readdata    = rdata_q;
   assign waitrequest = wait_q;
   assign irq         = irq_q;
   assign scl_o       = low_q;
   assign sda_o       = low_q;
   assign scl_oe      = scl_oe_q;
   assign sda_oe      = sda_oe_q;

endmodule

// File: test/stc_channel_props.sv
`timescale 1ns/1ps
// Checks bus timing, wire drivers and flag behaviour at the channel ports.
module stc_channel_props (
   // Clock and reset.
   input wire logic        core_clk,
   input wire logic        srst,
   // Register bus.
   input wire logic [5:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Wire drivers.
   input wire logic        scl_o,
   input wire logic        sda_o
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   wire  rd_ok = read && !waitrequest;  // Read taken at this edge.
   wire  wr_ok = write && !waitrequest; // Write taken at this edge.
   logic err_q;                         // Ack error as software last read it.
   logic en_q;                          // Enable state that software commanded.
   // Shadows change only on taken accesses, so a read alone never clears err_q.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         err_q <= 1'b0;
         en_q  <= 1'b0;
      end else begin
         if (rd_ok && address == stc_pkg::OFF_STATUS) err_q <= readdata[stc_pkg::ST_ACK_ERR];
         if (wr_ok && address == stc_pkg::OFF_FLAG_CLR && writedata[1]) err_q <= 1'b0;
         if (wr_ok && address == stc_pkg::OFF_STRT_TRG && writedata[0]) en_q <= 1'b1;
         if (wr_ok && address == stc_pkg::OFF_STOP_TRG && writedata[0]) en_q <= 1'b0;
      end
   end
   chk_wait_one: assert property ($fell(waitrequest) |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_answer: assert property ($rose(read || write) |=> !waitrequest)
      else $error("request not answered after one wait cycle");
   chk_wait_idle: assert property (!(read || write) |=> waitrequest)
      else $error("waitrequest low without a request");
   chk_od_low: assert property (!scl_o && !sda_o)
      else $error("open-drain output driven high");
   chk_unmapped_zero: assert property (rd_ok && address > stc_pkg::OFF_IRQ_MASK |-> !readdata)
      else $error("unmapped read not zero");
   chk_err_hold: assert property (rd_ok && address == stc_pkg::OFF_STATUS && err_q |-> readdata[1])
      else $error("ack error vanished without a clear");
   chk_en_track: assert property (rd_ok && address == stc_pkg::OFF_ENABLE |-> readdata[0] == en_q)
      else $error("enable status differs from triggers");
   chk_ctrl_zero: assert property (rd_ok && address == stc_pkg::OFF_CTRL |-> readdata[3:2] == 2'b00)
      else $error("condition command bits read back set");
endmodule
bind stc_channel stc_channel_props chk (.core_clk, .srst, .address, .read, .write, .writedata,
   .readdata, .waitrequest, .scl_o, .sda_o);

// File: test/stc_target.sv
`timescale 1ns/1ps
// Target on the wires: acks or refuses each byte, or sends one when read from.
module stc_target (
   // Wire levels.
   input wire logic       scl,
   input wire logic       sda,
   // Behaviour chosen by the bench.
   input wire logic       nack,
   input wire logic       send,
   input wire logic [7:0] tx_byte,
   // Pull-down on data and the last byte heard.
   output logic           sda_pull,
   output logic [7:0]     rx_byte
);
   int bit_n = 0; // Slot within the byte; slot 8 is the acknowledge.
   initial begin
      sda_pull = 1'b0;
      rx_byte  = 8'h00;
   end
   // A start or stop condition restarts the framing.
   always @(sda) if (scl) bit_n = 0;
   // Data is taken on the clock rise, first bit the most significant.
   always @(posedge scl) begin
      if (bit_n < 8) rx_byte = {rx_byte[6:0], sda};
      bit_n = bit_n + 1;
   end
   // The pull changes only while the clock is low; released data floats high.
   always @(negedge scl) begin
      if (bit_n == 9) bit_n = 0;
      sda_pull = (bit_n == 8) ? (!send && !nack) : (send && !tx_byte[7 - bit_n]);
   end
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
// Takes the channel through its error recovery paths against a target model.
module tb;
   logic        core_clk, srst, read, write, nack, send;
   logic [5:0]  address;
   logic [31:0] writedata, rd;
   logic [3:0]  byteenable;
   wire  [31:0] readdata;
   wire  [7:0]  got;
   wire         waitrequest, irq, scl_o, sda_o, scl_oe, sda_oe, pull;
   wire         scl = !scl_oe;          // Both wires have pull-ups.
   wire         sda = !(sda_oe || pull);
   int          fail_count = 0, num_checks = 0, cyc = 0;
   stc_channel dut (.core_clk, .srst, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .irq, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
   stc_target slv (.scl, .sda, .nack, .send, .tx_byte(8'hA5), .sda_pull(pull), .rx_byte(got));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = !core_clk;
   end
   // Cuts a hang short; all tests together need well under a thousand cycles.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One access; the request holds until waitrequest is sampled low, then an edge idles.
   // Only the bench timeout ends a wait that never gets its answer.
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      @(posedge core_clk);
      while (waitrequest !== 1'b0) begin
         @(posedge core_clk);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      cmp(what, exp, rd);
   endtask
   // Irq lags its cause by a cycle, so it is looked at once that edge has landed.
   task automatic irq_is(input logic exp);
      #1 cmp("irq", {31'h0, exp}, {31'h0, irq});
      @(posedge core_clk);
   endtask
   // Polls status until the engine is idle; rd then holds the status.
   task automatic idle();
      do begin
         bus(1'b0, stc_pkg::OFF_STATUS, 32'h0);
      end while (rd[stc_pkg::ST_BUSY] !== 1'b0);
   endtask
   task automatic t_reset();
      rdc(stc_pkg::OFF_STATUS, 32'h0, "status");
      rdc(stc_pkg::OFF_DATA, 32'h200, "data");
      rdc(6'h3C, 32'h0, "unmapped");
      bus(1'b1, stc_pkg::OFF_DATA, 32'h600);
      rdc(stc_pkg::OFF_STATUS, 32'h0, "no byte while stopped");
      rdc(stc_pkg::OFF_DATA, 32'h600, "divider");
      $display("test reset ended");
   endtask
   // Refused address byte, then clear, stop, stop and start conditions, restart.
   task automatic t_nack();
      nack <= 1'b1;
      bus(1'b1, stc_pkg::OFF_STRT_TRG, 32'h1);
      rdc(stc_pkg::OFF_ENABLE, 32'h1, "enable");
      bus(1'b1, stc_pkg::OFF_IRQ_MASK, 32'h2);
      bus(1'b1, stc_pkg::OFF_CTRL, 32'h4);
      rdc(stc_pkg::OFF_CTRL, 32'h0, "ctrl commands");
      idle();
      bus(1'b1, stc_pkg::OFF_DATA, 32'h6A4);
      idle();
      cmp("status", 32'h2, rd);
      cmp("sent", 32'hA4, {24'h0, got});
      irq_is(1'b1);
      bus(1'b1, stc_pkg::OFF_IRQ_MASK, 32'h0);
      irq_is(1'b0);
      rdc(stc_pkg::OFF_STATUS, 32'h2, "status held");
      bus(1'b1, stc_pkg::OFF_FLAG_CLR, 32'h1);
      rdc(stc_pkg::OFF_STATUS, 32'h2, "other flag kept");
      bus(1'b1, stc_pkg::OFF_FLAG_CLR, rd);
      rdc(stc_pkg::OFF_STATUS, 32'h0, "cleared");
      bus(1'b1, stc_pkg::OFF_IRQ_MASK, 32'h2);
      irq_is(1'b1);
      rdc(stc_pkg::OFF_IRQ_STAT, 32'h3, "irq causes");
      bus(1'b1, stc_pkg::OFF_IRQ_STAT, 32'h3);
      irq_is(1'b0);
      bus(1'b1, stc_pkg::OFF_STOP_TRG, 32'h1);
      rdc(stc_pkg::OFF_ENABLE, 32'h0, "stopped");
      bus(1'b1, stc_pkg::OFF_CTRL, 32'h8);
      idle();
      bus(1'b1, stc_pkg::OFF_CTRL, 32'h4);
      idle();
      bus(1'b1, stc_pkg::OFF_STRT_TRG, 32'h1);
      rdc(stc_pkg::OFF_ENABLE, 32'h1, "restarted");
      $display("test nack ended");
   endtask
   // Refused byte recovered by a repeated start and the address sent again.
   task automatic t_restart();
      bus(1'b1, stc_pkg::OFF_DATA, 32'h65C);
      idle();
      bus(1'b1, stc_pkg::OFF_FLAG_CLR, rd);
      nack <= 1'b0;
      bus(1'b1, stc_pkg::OFF_CTRL, 32'h4);
      idle();
      bus(1'b1, stc_pkg::OFF_DATA, 32'h65C);
      idle();
      cmp("status", 32'h0, rd);
      cmp("resent", 32'h5C, {24'h0, got});
      $display("test restart ended");
   endtask
   // Two bytes received without a read between them.
   task automatic t_overrun();
      send <= 1'b1;
      bus(1'b1, stc_pkg::OFF_CTRL, 32'h3);
      rdc(stc_pkg::OFF_CTRL, 32'h3, "rx mode");
      bus(1'b1, stc_pkg::OFF_DATA, 32'h600);
      idle();
      cmp("full", 32'h20, rd);
      bus(1'b1, stc_pkg::OFF_DATA, 32'h600);
      idle();
      cmp("overrun", 32'h21, rd);
      rdc(stc_pkg::OFF_DATA, 32'h6A5, "rx data");
      rdc(stc_pkg::OFF_STATUS, 32'h1, "after read");
      bus(1'b1, stc_pkg::OFF_FLAG_CLR, rd);
      rdc(stc_pkg::OFF_STATUS, 32'h0, "cleared");
      $display("test overrun ended");
   endtask
   initial begin
      srst = 1'b1;
      {read, write, nack, send} = 4'h0;
      address = 6'h00;
      writedata = 32'h0;
      byteenable = 4'hF;
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_nack();
      t_restart();
      t_overrun();
      test_done();
   end
endmodule
